// File: oag_core.sv
// operand address generation with register file, dispatch lookup and apb registers
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
// How it works
// RULE1: wide flag picks 16 or 32 bit entries
// RULE2: short entries reach only lowest 128K
// RULE3: table base register independent of entry width
// RULE4: short flag clear: index bases, return, stack 32-bit
// RULE5: pair low bits in lower register
// RULE6: byte write keeps destination high byte
// RULE7: immediate operand comes from instruction field
// RULE8: branch target is pc plus displacement
// RULE9: base plus displacement, base left untouched
// RULE10: index mode needs short flag clear
// RULE11: index base, pair, 14/20-bit displacement
// RULE12: index base plus 20-bit absolute
// RULE13: absolute address 20 or 24 bits
// RULE14: alu register-only; load, store, bit memory
// RULE15: byte load fills low 8 bits
// RULE16: doubleword high word to higher register
// RULE17: configuration clears to zero at reset
module oag_core
  import oag_pkg::*;
#(
  parameter int unsigned NREG = 16           // general registers
)(
  input  wire logic              mclk,         // core clock
  input  wire logic              nrst,         // async reset, active low
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // operand request from the decoder
  input  wire logic              req_valid,
  input  wire oag_op_e           req_op,
  input  wire oag_mode_e         req_mode,
  input  wire oag_size_e         req_size,
  input  wire logic [3:0]        req_rbase,    // base register or low reg of pair
  input  wire logic              req_idx_sel,  // 0 index_base_a, 1 index_base_b
  input  wire logic [23:0]       req_disp,     // displacement, immediate or absolute
  input  wire logic              req_long,     // 20-bit disp or 24-bit absolute
  input  wire logic [ADDR_W-1:0] pc,
  output logic                   ea_valid,
  output logic      [ADDR_W-1:0] ea_addr,
  output logic      [31:0]       opnd,
  output logic                   ea_fault,
  // result write back (loads and alu)
  input  wire logic              wb_valid,
  input  wire oag_size_e         wb_size,
  input  wire logic [3:0]        wb_dest,
  input  wire logic [31:0]       wb_data,
  // exception dispatch
  input  wire logic              exc_valid,
  input  wire logic [7:0]        exc_vector,
  output logic                   exc_fetch,
  output logic      [ADDR_W-1:0] exc_entry_addr,
  input  wire logic              ent_valid,
  input  wire logic [31:0]       ent_data,
  output logic                   handler_valid,
  output logic      [ADDR_W-1:0] handler_addr
);
  ////////////////////////////////////////////////////////////////////////////
  // all state
  typedef struct packed {
    logic [NREG-1:0][31:0] rf;          // r0..r11 use low 16 bits only
    logic [15:0]           cfg;         // core_configuration
    logic [ADDR_W-1:0]     dbase;       // dispatch_table_base
    oag_bus_e              bus;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  ea_valid;
    logic [ADDR_W-1:0]     ea_addr;
    logic [31:0]           opnd;
    logic                  ea_fault;
    logic                  exc_fetch;
    logic [ADDR_W-1:0]     exc_entry;
    logic                  h_valid;
    logic [ADDR_W-1:0]     h_addr;
  } oag_state_s;

  oag_state_s st_q;                      // registered state
  oag_state_s st_d;                      // next state

  logic              wide_ent;           // dispatch_entry_width_sel
  logic              short_regs;         // short_register_compat
  logic [ADDR_W-1:0] dsp_entry;          // entry address from dispatch decode
  logic [ADDR_W-1:0] dsp_handler;        // handler from dispatch decode

  assign wide_ent   = st_q.cfg[CFG_WID_BIT];
  assign short_regs = st_q.cfg[CFG_SHT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // dispatch table decode
  oag_dispatch u_dsp (
    .wide_ent   (wide_ent),
    .dbase      (st_q.dbase),
    .vector     (exc_vector),
    .entry      (ent_data),
    .entry_addr (dsp_entry),
    .handler    (dsp_handler)
  );

  ////////////////////////////////////////////////////////////////////////////
  // single register read: dedicated regs are 32 bits unless the short flag is set
  function automatic logic [31:0] rd_reg(input oag_state_s s, input logic [3:0] n,
                                         input logic srm);
    logic [31:0] v;
    v = s.rf[n];
    if (n < IDXA_REG || srm) begin
      v = {16'h0000, v[15:0]}; // RULE4
    end
    return v;
  endfunction

  // pair read: low half from the lower register, high from the next one; a dedicated reg is read whole while the short flag is clear
  function automatic logic [31:0] rd_pair(input oag_state_s s, input logic [3:0] n,
                                          input logic srm);
    logic [31:0] v;
    logic [3:0]  hi;
    hi = n + 4'h1;
    if (n >= IDXA_REG && !srm) begin
      v = s.rf[n]; // RULE4
    end else begin
      v = {s.rf[hi][15:0], s.rf[n][15:0]}; // RULE5
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [31:0]       base;
    logic [31:0]       pair;
    logic [31:0]       idx;
    logic [31:0]       dsp;
    logic [31:0]       sum;
    logic              mem;
    logic [3:0]        hi;
    logic [3:0]        widx;
    logic              wmap;
    base = 32'h0;
    pair = 32'h0;
    idx  = 32'h0;
    dsp  = 32'h0;
    sum  = 32'h0;
    mem  = 1'b0;
    hi   = 4'h0;
    widx = 4'h0;
    wmap = 1'b0;
    st_d = st_q;
    // pulses last one cycle
    st_d.ea_valid  = 1'b0;
    st_d.exc_fetch = 1'b0;
    st_d.h_valid   = 1'b0;

    // operand address for one request
    if (req_valid) begin
      base = rd_reg(st_q, req_rbase, short_regs);
      pair = rd_pair(st_q, req_rbase, short_regs);
      idx  = rd_reg(st_q, req_idx_sel ? IDXB_REG : IDXA_REG, short_regs); // RULE10
      mem  = 1'b1;
      st_d.ea_fault = 1'b0;
      st_d.opnd     = 32'h0;
      case (req_mode)
        OAG_M_REG: begin
          mem = 1'b0;
          st_d.opnd = (req_size == OAG_SZ_DWORD) ? pair : base; // RULE5
          sum = 32'h0;
        end
        OAG_M_IMM: begin
          mem = 1'b0;
          st_d.opnd = {8'h00, req_disp}; // RULE7
          sum = 32'h0;
        end
        OAG_M_REL: begin
          sum = base + {8'h00, req_disp}; // RULE9
        end
        OAG_M_RELP: begin
          sum = pair + {8'h00, req_disp}; // RULE9
        end
        OAG_M_IDXR: begin
          dsp = req_long ? {12'h000, req_disp[IDX_DISP_L-1:0]}
                         : {18'h00000, req_disp[IDX_DISP_S-1:0]};
          sum = idx + pair + dsp; // RULE11
          st_d.ea_fault = short_regs; // RULE10
        end
        OAG_M_IDXA: begin
          sum = idx + {12'h000, req_disp[IDX_ABS_W-1:0]}; // RULE12
          st_d.ea_fault = short_regs; // RULE10
        end
        OAG_M_ABS: begin
          // RULE13
          sum = req_long ? {8'h00, req_disp[ABS_L-1:0]}
                         : {12'h000, req_disp[ABS_S-1:0]};
        end
        OAG_M_PCR: begin
          mem = 1'b0;
          sum = {8'h00, pc} + {{8{req_disp[23]}}, req_disp}; // RULE8
        end
        default: begin
          sum = 32'h0;
          st_d.ea_fault = 1'b1;
        end
      endcase
      // alu work never touches memory; bit ops may
      if (req_op == OAG_OP_ALU && mem) begin
        st_d.ea_fault = 1'b1; // RULE14
      end
      // truncation to the bus width is intended
      st_d.ea_addr  = sum[ADDR_W-1:0];
      st_d.ea_valid = 1'b1;
    end

    // result write back into the register file
    if (wb_valid) begin
      hi = wb_dest + 4'h1;
      case (wb_size)
        OAG_SZ_BYTE: begin
          st_d.rf[wb_dest][7:0] = wb_data[7:0]; // RULE6 RULE15
        end
        OAG_SZ_WORD: begin
          st_d.rf[wb_dest][15:0] = wb_data[15:0];
        end
        OAG_SZ_DWORD: begin
          if (wb_dest >= IDXA_REG && !short_regs) begin
            st_d.rf[wb_dest] = wb_data; // RULE4
          end else begin
            st_d.rf[wb_dest][15:0] = wb_data[15:0]; // RULE16
            // the top register has no partner; its high word is dropped
            if (wb_dest != STK_REG) begin
              st_d.rf[hi][15:0] = wb_data[31:16]; // RULE16
            end
          end
        end
        default: begin
          st_d.rf[wb_dest][15:0] = wb_data[15:0];
        end
      endcase
    end

    // exception dispatch: entry fetch then handler decode
    if (exc_valid) begin
      st_d.exc_entry = dsp_entry; // RULE3
      st_d.exc_fetch = 1'b1;
    end
    if (ent_valid) begin
      st_d.h_addr  = dsp_handler; // RULE2
      st_d.h_valid = 1'b1;
    end

    // apb: setup cycle loads the answer, access cycle completes it
    widx = paddr[5:2];
    wmap = (paddr[7:6] == REG_OFS[7:6]);
    case (st_q.bus)
      OAG_BUS_IDLE: begin
        st_d.pready = 1'b0;
        if (psel && !penable) begin
          st_d.bus     = OAG_BUS_ANS;
          st_d.pready  = 1'b1;
          st_d.pslverr = 1'b0;
          st_d.prdata  = 32'h0;
          if (paddr == CFG_OFS) begin
            st_d.prdata = {16'h0000, st_q.cfg};
          end else if (paddr == DBASE_OFS) begin
            st_d.prdata = {8'h00, st_q.dbase};
          end else if (paddr == EA_OFS) begin
            st_d.prdata = {st_q.ea_fault, 7'h00, st_q.ea_addr};
            st_d.pslverr = pwrite;
          end else if (wmap && paddr[1:0] == 2'b00) begin
            st_d.prdata = rd_reg(st_q, widx, 1'b0);
          end else begin
            st_d.pslverr = 1'b1;
          end
        end
      end
      OAG_BUS_ANS: begin
        st_d.bus     = OAG_BUS_IDLE;
        st_d.pready  = 1'b0;
        st_d.pslverr = 1'b0;
        if (psel && penable && pwrite && !st_q.pslverr) begin
          if (paddr == CFG_OFS) begin
            st_d.cfg = pwdata[15:0] & CFG_WMASK;
          end else if (paddr == DBASE_OFS) begin
            st_d.dbase = pwdata[ADDR_W-1:0];
          end else if (wmap) begin
            // r0..r11 keep only 16 bits; the dedicated registers r12..r15 take all 32
            st_d.rf[widx] = (widx < IDXA_REG) ? {16'h0000, pwdata[15:0]} : pwdata;
          end
        end
      end
      default: begin
        st_d.bus    = OAG_BUS_IDLE;
        st_d.pready = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q       <= '0;
      st_q.cfg   <= CFG_RST; // RULE17
      st_q.dbase <= DBASE_RST;
      st_q.bus   <= OAG_BUS_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign prdata         = st_q.prdata;
  assign pready         = st_q.pready;
  assign pslverr        = st_q.pslverr;
  assign ea_valid       = st_q.ea_valid;
  assign ea_addr        = st_q.ea_addr;
  assign opnd           = st_q.opnd;
  assign ea_fault       = st_q.ea_fault;
  assign exc_fetch      = st_q.exc_fetch;
  assign exc_entry_addr = st_q.exc_entry;
  assign handler_valid  = st_q.h_valid;
  assign handler_addr   = st_q.h_addr;
endmodule

// File: oag_pkg.sv
// shared constants and types of the operand address generator
package oag_pkg;
  localparam int unsigned ADDR_W      = 24;        // core address width
  localparam int unsigned APB_AW      = 8;         // apb address width
  // register byte offsets
  localparam logic [7:0]  CFG_OFS     = 8'h00;     // core_configuration
  localparam logic [7:0]  DBASE_OFS   = 8'h04;     // dispatch_table_base
  localparam logic [7:0]  EA_OFS      = 8'h08;     // last effective address, read only
  localparam logic [7:0]  REG_OFS     = 8'h40;     // register file window, 16 words
  // core_configuration fields and reset values
  localparam int unsigned CFG_WID_BIT = 8;         // dispatch_entry_width_sel
  localparam int unsigned CFG_SHT_BIT = 9;         // short_register_compat
  localparam logic [15:0] CFG_RST     = 16'h0000;
  localparam logic [15:0] CFG_WMASK   = 16'h0300;  // only the two mode bits are writable
  localparam logic [23:0] DBASE_RST   = 24'h000000;
  // dispatch entries
  localparam int unsigned ENT_SHORT_W = 16;        // entry width with the wide flag clear
  localparam int unsigned ENT_LONG_W  = 32;        // entry width with the wide flag set
  localparam int unsigned LOW_SPAN_W  = 17;        // 128K reach of short entries
  // displacement and absolute field widths
  localparam int unsigned IDX_DISP_S  = 14;
  localparam int unsigned IDX_DISP_L  = 20;
  localparam int unsigned IDX_ABS_W   = 20;
  localparam int unsigned ABS_S       = 20;
  localparam int unsigned ABS_L       = 24;
  // dedicated register numbers
  localparam logic [3:0]  IDXA_REG    = 4'hc;      // index_base_a
  localparam logic [3:0]  IDXB_REG    = 4'hd;      // index_base_b
  localparam logic [3:0]  RET_REG     = 4'he;      // return_address_reg
  localparam logic [3:0]  STK_REG     = 4'hf;      // stack_pointer_reg

  typedef enum logic [2:0] {
    OAG_M_REG  = 3'h0, OAG_M_IMM  = 3'h1, OAG_M_REL  = 3'h2, OAG_M_RELP = 3'h3,
    OAG_M_IDXR = 3'h4, OAG_M_IDXA = 3'h5, OAG_M_ABS  = 3'h6, OAG_M_PCR  = 3'h7
  } oag_mode_e;

  typedef enum logic [1:0] {
    OAG_OP_ALU = 2'h0, OAG_OP_LOAD = 2'h1, OAG_OP_STORE = 2'h2, OAG_OP_BIT = 2'h3
  } oag_op_e;

  typedef enum logic [1:0] {
    OAG_SZ_BYTE = 2'h0, OAG_SZ_WORD = 2'h1, OAG_SZ_DWORD = 2'h2
  } oag_size_e;

  // apb phase machine, gray along idle -> answer -> idle
  typedef enum logic [1:0] {
    OAG_BUS_IDLE = 2'b00, OAG_BUS_ANS = 2'b01
  } oag_bus_e;
endpackage

// File: oag_dispatch.sv
// dispatch table entry address and handler address decode
`timescale 1ns/100ps
module oag_dispatch
  import oag_pkg::*;
(
  input  wire logic              wide_ent,    // dispatch_entry_width_sel
  input  wire logic [ADDR_W-1:0] dbase,       // dispatch_table_base
  input  wire logic [7:0]        vector,      // exception number
  input  wire logic [31:0]       entry,       // fetched table entry
  output logic      [ADDR_W-1:0] entry_addr,  // where the entry lives
  output logic      [ADDR_W-1:0] handler      // decoded handler address
);
  ////////////////////////////////////////////////////////////////////////////
  // the base is used as is for both widths; only the stride changes
  always_comb begin
    if (wide_ent) begin
      entry_addr = dbase + {14'h0000, vector, 2'b00}; // RULE1 RULE3
    end else begin
      entry_addr = dbase + {15'h0000, vector, 1'b0}; // RULE1 RULE3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // short entries hold a halfword-aligned address, so they reach only 128K
  always_comb begin
    if (wide_ent) begin
      handler = entry[ADDR_W-1:0]; // RULE1
    end else begin
      handler = {{(ADDR_W-LOW_SPAN_W){1'b0}}, entry[ENT_SHORT_W-1:0], 1'b0}; // RULE2
    end
  end
endmodule

// File: oag_core_chk.sv
// port-level assertions of the operand address generator
`timescale 1ns/100ps
module oag_core_chk
  import oag_pkg::*;
(
  input wire logic              mclk,
  input wire logic              nrst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              req_valid,
  input wire oag_op_e           req_op,
  input wire oag_mode_e         req_mode,
  input wire logic [23:0]       req_disp,
  input wire logic              req_long,
  input wire logic [ADDR_W-1:0] pc,
  input wire logic              ea_valid,
  input wire logic [ADDR_W-1:0] ea_addr,
  input wire logic              ea_fault,
  input wire logic              exc_valid,
  input wire logic              exc_fetch,
  input wire logic              ent_valid,
  input wire logic              handler_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // apb setup, then the single answer cycle
  sequence s_setup;
    psel && !penable;
  endsequence
  // pc-relative and absolute requests that are not alu ops
  sequence s_pcr;
    req_valid && req_mode == OAG_M_PCR && req_op != OAG_OP_ALU;
  endsequence
  sequence s_abs;
    req_valid && req_mode == OAG_M_ABS && req_op != OAG_OP_ALU;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_APB_ANSWER: assert property (s_setup |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");
  AST_EA_LATENCY: assert property (req_valid |=> ea_valid)
    else $error("ea_valid missing after request");
  AST_EA_PULSE: assert property (!req_valid |=> !ea_valid)
    else $error("ea_valid without request");
  AST_PCR_TARGET: assert property (s_pcr |=> ea_addr == $past(pc) + $past(req_disp))
    else $error("branch target not pc plus displacement");
  AST_ABS_FIELD: assert property (s_abs |=> ea_addr == ($past(req_long) ?
    $past(req_disp) : {4'h0, $past(req_disp[19:0])}) && !ea_fault)
    else $error("absolute address not taken from field");
  AST_ALU_MEM_FAULT: assert property (req_valid && req_op == OAG_OP_ALU &&
    req_mode inside {OAG_M_REL, OAG_M_RELP, OAG_M_IDXR, OAG_M_IDXA, OAG_M_ABS} |=> ea_fault)
    else $error("alu op reached memory");
  AST_REG_NO_ADDR: assert property (req_valid &&
    req_mode inside {OAG_M_REG, OAG_M_IMM} |=> ea_addr == 24'h000000)
    else $error("register or immediate operand produced an address");
  AST_EXC_FETCH: assert property (exc_valid |=> exc_fetch)
    else $error("entry fetch missing after exception");
  AST_HANDLER: assert property (ent_valid |=> handler_valid)
    else $error("handler missing after entry");
endmodule
bind oag_core oag_core_chk u_chk (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
  .pready(pready), .req_valid(req_valid), .req_op(req_op), .req_mode(req_mode),
  .req_disp(req_disp), .req_long(req_long), .pc(pc), .ea_valid(ea_valid), .ea_addr(ea_addr),
  .ea_fault(ea_fault), .exc_valid(exc_valid), .exc_fetch(exc_fetch), .ent_valid(ent_valid),
  .handler_valid(handler_valid));

// File: operand_address_generation_test.sv
// self-checking bench of the operand address generator
`timescale 1ns/100ps
module operand_address_generation_test;
  import oag_pkg::*;
  logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, req_valid, req_idx_sel;
  logic        req_long, ea_valid, ea_fault, wb_valid, exc_valid, exc_fetch, ent_valid;
  logic        handler_valid, e, x, l, short_regs, wide_ent;
  logic [7:0]  paddr, exc_vector, v;
  logic [31:0] pwdata, prdata, opnd, wb_data, ent_data, r, rf[16];
  logic [23:0] req_disp, pc, ea_addr, exc_entry_addr, handler_addr, d, base;
  logic [3:0]  req_rbase, wb_dest, b;
  oag_op_e     req_op;
  oag_mode_e   req_mode, m;
  oag_size_e   req_size, wb_size;
  int          mismatches, total_checks;
  oag_mode_e   modes[6] = '{OAG_M_REL, OAG_M_RELP, OAG_M_IDXR, OAG_M_IDXA, OAG_M_ABS, OAG_M_PCR};
  oag_core u_dut (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .req_valid, .req_op, .req_mode, .req_size, .req_rbase, .req_idx_sel, .req_disp,
    .req_long, .pc, .ea_valid, .ea_addr, .opnd, .ea_fault, .wb_valid, .wb_size, .wb_dest,
    .wb_data, .exc_valid, .exc_vector, .exc_fetch, .exc_entry_addr, .ent_valid, .ent_data,
    .handler_valid, .handler_addr);
  ////////////////////////////////////////////////////////////////////////////////
  // 40 mhz core clock
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  // hang guard, well past the longest sequence
  initial begin
    #2000000;
    mismatches++;
    summarize();
  end
  task summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // apb master: request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge mclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      mismatches++;
      summarize();
    end
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // write back; the model mirrors the sized update
  task wb(input oag_size_e s, input logic [3:0] n, input logic [31:0] dv);
    @(posedge mclk);
    wb_valid <= 1; wb_size <= s; wb_dest <= n; wb_data <= dv;
    @(posedge mclk);
    wb_valid <= 0;
    if (s == OAG_SZ_BYTE) rf[n][7:0] = dv[7:0];
    else if (s == OAG_SZ_WORD) rf[n][15:0] = dv[15:0];
    else if (n >= 12 && !short_regs) rf[n] = dv;
    else begin
      rf[n][15:0] = dv[15:0];
      if (n != 15) rf[n+1][15:0] = dv[31:16];
    end
  endtask
  // one operand request, answer sampled exactly one cycle later
  task rq(input oag_op_e o, input oag_mode_e md, input oag_size_e s);
    @(posedge mclk);
    req_valid <= 1; req_op <= o; req_mode <= md; req_size <= s; req_rbase <= b;
    req_idx_sel <= x; req_disp <= d; req_long <= l;
    @(posedge mclk);
    req_valid <= 0;
    @(posedge mclk);
    chk(ea_valid, 1);
  endtask
  function automatic logic [31:0] pair(input logic [3:0] n);
    return (n >= 12 && !short_regs) ? rf[n] : {rf[n+1][15:0], rf[n][15:0]};
  endfunction
  function automatic logic [23:0] ea_exp(input oag_mode_e md);
    case (md)
      OAG_M_REL:  return 24'(rf[b] + d);
      OAG_M_RELP: return 24'(pair(b) + d);
      OAG_M_IDXR: return 24'(rf[12+x] + pair(b) + (l ? d[19:0] : d[13:0]));
      OAG_M_IDXA: return 24'(rf[12+x] + d[19:0]);
      OAG_M_ABS:  return l ? d : {4'h0, d[19:0]};
      default:    return pc + d;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, req_valid, req_idx_sel, req_long, wb_valid, exc_valid} = '0;
    {paddr, pwdata, req_disp, pc, req_rbase, wb_dest, wb_data, exc_vector, ent_valid} = '0;
    {ent_data, mismatches, total_checks, short_regs, wide_ent, b, x, l, d} = '0;
    req_op = OAG_OP_LOAD; req_mode = OAG_M_REG; req_size = OAG_SZ_WORD; wb_size = OAG_SZ_WORD;
    foreach (rf[i]) rf[i] = '0;
    nrst = 0;
    r = $urandom(99);
    repeat (8) @(posedge mclk);
    nrst <= 1;
    apb(0, CFG_OFS, 0); chk(r, 32'h0);
    apb(0, DBASE_OFS, 0); chk(r, 32'h0);
    apb(1, CFG_OFS, 32'hffffffff); apb(0, CFG_OFS, 0); chk(r, 32'h00000300);
    apb(1, CFG_OFS, 0); apb(0, 8'h20, 0); chk(e, 1);
    apb(1, EA_OFS, 32'h1); chk(e, 1);
    for (int n = 0; n < 14; n++) wb(n < 12 ? OAG_SZ_WORD : OAG_SZ_DWORD, 4'(n), $urandom);
    wb(OAG_SZ_BYTE, 2, $urandom); apb(0, REG_OFS + 8'h08, 0); chk(r, rf[2]);
    wb(OAG_SZ_DWORD, 6, $urandom); apb(0, REG_OFS + 8'h1c, 0); chk(r, rf[7]);
    b = 6; rq(OAG_OP_LOAD, OAG_M_REG, OAG_SZ_DWORD); chk(opnd, pair(6));
    d = 24'($urandom); rq(OAG_OP_LOAD, OAG_M_IMM, OAG_SZ_WORD); chk(opnd, {8'h0, d});
    // random address modes, every mode but register and immediate, and both field widths
    for (int i = 0; i < 48; i++) begin
      b = 4'($urandom % 11); x = $urandom; d = $urandom; l = $urandom; pc <= $urandom;
      rq(OAG_OP_LOAD, modes[i%6], OAG_SZ_WORD);
      chk(ea_addr, ea_exp(modes[i%6]));
      chk(ea_fault, 0);
    end
    // forming addresses leaves every base register untouched
    for (int n = 0; n < 14; n++) begin
      apb(0, 8'(REG_OFS + 4 * n), 0); chk(r, rf[n]);
    end
    b = 4; d = 24'h10;
    rq(OAG_OP_ALU, OAG_M_REL, OAG_SZ_WORD); chk(ea_fault, 1);
    rq(OAG_OP_BIT, OAG_M_REL, OAG_SZ_WORD); chk(ea_fault, 0);
    apb(1, CFG_OFS, 32'h200); short_regs = 1;
    rq(OAG_OP_LOAD, OAG_M_IDXR, OAG_SZ_WORD); chk(ea_fault, 1);
    rq(OAG_OP_STORE, OAG_M_IDXA, OAG_SZ_WORD); chk(ea_fault, 1);
    // dispatch lookup with both entry widths
    for (int k = 0; k < 4; k++) begin
      wide_ent = k[0];
      short_regs = 0;
      base = $urandom;
      v = $urandom;
      ent_data <= $urandom;
      apb(1, DBASE_OFS, {8'h0, base}); apb(1, CFG_OFS, {23'h0, wide_ent, 8'h0});
      apb(0, DBASE_OFS, 0); chk(r, {8'h0, base});
      @(posedge mclk);
      exc_valid <= 1; exc_vector <= v;
      @(posedge mclk);
      exc_valid <= 0; ent_valid <= 1;
      @(posedge mclk);
      ent_valid <= 0;
      chk(exc_fetch, 1); chk(exc_entry_addr, 24'(base + (wide_ent ? 4 * v : 2 * v)));
      @(posedge mclk);
      chk(handler_valid, 1);
      chk(handler_addr, wide_ent ? ent_data[23:0] : {7'h0, ent_data[15:0], 1'b0});
    end
    summarize();
  end
endmodule
